// >>> hw/hmi_pkg.sv
package hmi_pkg;

   // Host port offsets (low three bits of the I/O address).
   localparam logic [2:0] PORT_SELFTEST_CODE_A = 3'h0;
   localparam logic [2:0] PORT_SELFTEST_CODE_B = 3'h4;
   localparam logic [2:0] PORT_INDEX  = 3'h5;
   localparam logic [2:0] PORT_DATA   = 3'h6;

   // Internal indices reached through the index/data port pair.
   localparam logic [6:0] IDX_SELFTEST_CODE_LAST  = 7'h1f;
   localparam logic [6:0] IDX_OVER_TEMP  = 7'h39;
   localparam logic [6:0] IDX_HYST       = 7'h3a;
   localparam logic [6:0] IDX_CFG        = 7'h40;
   localparam logic [6:0] IDX_STAT1      = 7'h41;
   localparam logic [6:0] IDX_STAT2      = 7'h42;
   localparam logic [6:0] IDX_MGMT_MASK1 = 7'h43;
   localparam logic [6:0] IDX_MGMT_MASK2 = 7'h44;
   localparam logic [6:0] IDX_HOST_MASK1 = 7'h45;
   localparam logic [6:0] IDX_HOST_MASK2 = 7'h46;

   // Configuration register fields.
   localparam int CFG_START      = 0;
   localparam int CFG_MGMT_EN    = 1;
   localparam int CFG_HOST_EN    = 2;
   localparam int CFG_LINE_CLEAR = 3;
   localparam int CFG_RESET      = 4;
   localparam int CFG_HOST_SEL   = 5;
   localparam int CFG_HOLD       = 6;
   localparam int CFG_INIT       = 7;

   // Status and mask fields.
   localparam int ST1_TEMP    = 4;
   localparam int ST2_OVF     = 5;
   localparam int MASK2_PULSE = 7;

   // Values after reset, and the hysteresis value that selects thermostat mode.
   localparam logic [7:0]  CFG_RST        = 8'h08;
   localparam logic [7:0]  MASK_RST       = 8'h00;
   localparam logic [7:0]  HOST_MASK2_RST = 8'h40;
   localparam logic [7:0]  OVER_TEMP_RST  = 8'h3c;
   localparam logic [7:0]  HYST_RST       = 8'h32;
   localparam logic [7:0]  THERMOSTAT     = 8'h7f;
   localparam logic [11:0] SYNC_RST       = 12'hffd;

   // Self-test code store.
   localparam int         SELFTEST_CODE_DEPTH = 32;
   localparam logic [5:0] SELFTEST_CODE_FULL  = 6'h20;

   // Timing: the open-drain pulses last at least 20 ms.
   localparam int CLK_FREQ_KHZ  = 25000;
   localparam int PULSE_TIME_MS = 20;
   localparam int PULSE_CYCLES  = PULSE_TIME_MS * CLK_FREQ_KHZ;

   typedef enum logic {TMP_WAIT_HOT, TMP_WAIT_COOL} hmi_temp_state_t;

endpackage

// >>> hw/hmi_top.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Latched mode: over-limit sets flag until read.
// - After clearing, next flag comes below hysteresis.
// - Hysteresis 127 gives thermostat re-setting each cycle.
// - Comparator flag stops with the first reading not above the limit.
// - Every voltage, temperature, fan limit raises source.
// - Over 32 code writes: overflow flag, pointer stops.
// - Board alert input is active-low source.
// - Chassis input is active-high latched source.
// - Host mask2 bit7 pulls chassis low, self-clears.
// - Chained active-low input is maskable management source.
// - Two status registers, separate masks per output.
// - Config enables both lines, selects host mode.
// - Status read returns, clears, drops the line.
// - Line-clear bit silences lines, halts monitoring.
// - Config bit6 drives supply-hold output low.
// - Reset output works only with mask2 bit7.
// - Config bit4 gives 20 ms reset, self-clears.
// - Code port writes store byte, advance pointer.
// - Store readable at 00h-1Fh with separate pointer.
// - Tester pulling management line low enters tree mode.
// - Tree output toggles with any included pin.
// - Line-clear leaves status contents untouched.
// - Host mode bit one selects non-maskable style.
// - Mask bit one excludes flag from management line.
module hmi_top #(
   parameter int PULSE_CYCLES = hmi_pkg::PULSE_CYCLES
) (
   // Clock and reset
   input  wire logic       SYS_CLK,
   input  wire logic       SRST,
   // Register port
   input  wire logic [2:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // Monitoring loop results
   input  wire logic       MEAS_DONE,
   input  wire logic [7:0] TEMP_VALUE,
   input  wire logic [6:0] VOLT_FAULT,
   input  wire logic [2:0] FAN_FAULT,
   output logic            MON_RUN,
   // External interrupt pins
   input  wire logic       BTI_N,
   input  wire logic       CHAINED_N,
   input  wire logic       CHASSIS_I,
   output logic            CHASSIS_O,
   output logic            CHASSIS_OE,
   // Interrupt outputs
   input  wire logic       MGMT_IRQ_I,
   output logic            MGMT_IRQ_O,
   output logic            MGMT_IRQ_OE,
   output logic            HOST_IRQ_N,
   output logic            HOST_IRQ_OE,
   output logic            HOST_IRQ_NMI,
   // Open-drain control outputs
   output logic            RESET_O,
   output logic            RESET_OE,
   output logic            HOLD_O,
   output logic            HOLD_OE,
   // Board test
   input  wire logic [7:0] TREE_IN,
   output logic            TREE_TEST_OUT
);

   localparam logic [18:0] PULSE_END = 19'(PULSE_CYCLES - 1);

   logic [11:0]                 sync_a;
   logic [11:0]                 sync_b;
   logic [11:0]                 chain;
   logic [7:0]                  cfg;
   logic [7:0]                  stat1;
   logic [7:0]                  stat2;
   logic [7:0]                  mgmt_mask1;
   logic [7:0]                  mgmt_mask2;
   logic [7:0]                  host_mask1;
   logic [7:0]                  host_mask2;
   logic [7:0]                  over_temp_limit;
   logic [7:0]                  temp_hysteresis_limit;
   logic [6:0]                  index;
   logic [5:0]                  wr_ptr;
   logic [7:0]                  selftest_code_mem [hmi_pkg::SELFTEST_CODE_DEPTH];
   logic [7:0]                  rd_value;
   logic [7:0]                  set1;
   logic [7:0]                  set2;
   logic [1:0]                  pulse_busy;
   logic [1:0]                  pulse_trig;
   logic [1:0]                  pulse_done;
   logic [18:0]                 pulse_cnt [2];
   logic                        cfg_written;
   logic                        tree_mode;
   hmi_pkg::hmi_temp_state_t    temp_state;
   hmi_pkg::hmi_temp_state_t    next_temp_state;
   logic                        temp_ev;
   logic                        run;
   logic                        wr_data;
   logic                        rd_data;
   logic                        selftest_code_wr;
   logic                        soft_init;
   logic                        clear1;
   logic                        clear2;
   logic                        in_selftest_code;
   logic                        pend_mgmt;
   logic                        pend_host;
   logic                        bti_act;
   logic                        chassis_act;
   logic                        chain_act;
   logic                        mgmt_pin;

   // Pins from outside the clock domain pass two flops first.
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         sync_a <= hmi_pkg::SYNC_RST;
         sync_b <= hmi_pkg::SYNC_RST;
      end else begin
         sync_a <= {TREE_IN, MGMT_IRQ_I, CHAINED_N, CHASSIS_I, BTI_N};
         sync_b <= sync_a;
      end
   end

   assign bti_act     = ~sync_b[0];
   assign chassis_act = sync_b[1];
   assign chain_act   = ~sync_b[2];
   assign mgmt_pin    = sync_b[3];

   // Register port decode.
   assign wr_data   = WR && (ADDR == hmi_pkg::PORT_DATA);
   assign rd_data   = RD && (ADDR == hmi_pkg::PORT_DATA);
   assign selftest_code_wr   = WR && (ADDR == hmi_pkg::PORT_SELFTEST_CODE_A || ADDR == hmi_pkg::PORT_SELFTEST_CODE_B);
   assign in_selftest_code   = (index <= hmi_pkg::IDX_SELFTEST_CODE_LAST);
   assign soft_init = wr_data && (index == hmi_pkg::IDX_CFG) && WDATA[hmi_pkg::CFG_INIT];
   assign clear1    = rd_data && (index == hmi_pkg::IDX_STAT1);
   assign clear2    = rd_data && (index == hmi_pkg::IDX_STAT2);
   assign run       = cfg[hmi_pkg::CFG_START] && !cfg[hmi_pkg::CFG_LINE_CLEAR];

   // Index register; data-port access to the code store steps it, which is the
   // read pointer and is independent of the host write pointer.
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         index <= 7'h00;
      end else if (WR && ADDR == hmi_pkg::PORT_INDEX) begin
         index <= WDATA[6:0];
      end else if ((rd_data || wr_data) && in_selftest_code) begin
         index <= {2'b00, index[4:0] + 5'h01};
      end
   end

   // Configuration; hardware clears the pulse bit, a software write wins.
   always_ff @(posedge SYS_CLK) begin
      if (SRST || soft_init) begin
         cfg <= hmi_pkg::CFG_RST;
      end else begin
         if (pulse_done[0]) begin
            cfg[hmi_pkg::CFG_RESET] <= 1'b0;
         end
         if (wr_data && index == hmi_pkg::IDX_CFG) begin
            cfg <= WDATA;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         cfg_written <= 1'b0;
      end else if (wr_data && index == hmi_pkg::IDX_CFG) begin
         cfg_written <= 1'b1;
      end
   end

   // Masks and temperature limits.
   always_ff @(posedge SYS_CLK) begin
      if (SRST || soft_init) begin
         mgmt_mask1            <= hmi_pkg::MASK_RST;
         mgmt_mask2            <= hmi_pkg::MASK_RST;
         host_mask1            <= hmi_pkg::MASK_RST;
         host_mask2            <= hmi_pkg::HOST_MASK2_RST;
         over_temp_limit       <= hmi_pkg::OVER_TEMP_RST;
         temp_hysteresis_limit <= hmi_pkg::HYST_RST;
      end else begin
         if (pulse_done[1]) begin
            host_mask2[hmi_pkg::MASK2_PULSE] <= 1'b0;
         end
         if (wr_data) begin
            unique case (index)
               hmi_pkg::IDX_MGMT_MASK1: mgmt_mask1 <= WDATA;
               hmi_pkg::IDX_MGMT_MASK2: mgmt_mask2 <= WDATA;
               hmi_pkg::IDX_HOST_MASK1: host_mask1 <= WDATA;
               hmi_pkg::IDX_HOST_MASK2: host_mask2 <= WDATA;
               hmi_pkg::IDX_OVER_TEMP:  over_temp_limit <= WDATA;
               hmi_pkg::IDX_HYST:       temp_hysteresis_limit <= WDATA;
               default: ;
            endcase
         end
      end
   end

   // Temperature event. With the hysteresis limit at its top value the
   // detector never arms for cooling, so the flag is re-set every cycle that
   // stays hot and simply stops once a reading is no longer above the limit.
   always_comb begin
      next_temp_state = temp_state;
      temp_ev         = 1'b0;
      if (MEAS_DONE && run) begin
         if (temp_hysteresis_limit == hmi_pkg::THERMOSTAT) begin
            temp_ev         = $signed(TEMP_VALUE) > $signed(over_temp_limit);
            next_temp_state = hmi_pkg::TMP_WAIT_HOT;
         end else begin
            unique case (temp_state)
               hmi_pkg::TMP_WAIT_HOT: begin
                  if ($signed(TEMP_VALUE) > $signed(over_temp_limit)) begin
                     temp_ev         = 1'b1;
                     next_temp_state = hmi_pkg::TMP_WAIT_COOL;
                  end
               end
               hmi_pkg::TMP_WAIT_COOL: begin
                  if ($signed(TEMP_VALUE) < $signed(temp_hysteresis_limit)) begin
                     temp_ev         = 1'b1;
                     next_temp_state = hmi_pkg::TMP_WAIT_HOT;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST || soft_init) begin
         temp_state <= hmi_pkg::TMP_WAIT_HOT;
      end else begin
         temp_state <= next_temp_state;
      end
   end

   // Sources. Loop results only count at the end of a measurement.
   always_comb begin
      set1 = 8'h00;
      set2 = 8'h00;
      if (MEAS_DONE && run) begin
         set1 = {FAN_FAULT[1:0], 2'b00, VOLT_FAULT[3:0]};
         set2 = {4'h0, FAN_FAULT[2], VOLT_FAULT[6:4]};
      end
      set1[hmi_pkg::ST1_TEMP] = temp_ev;
      set1[5]                 = bti_act && run;
      set2[4]                 = chassis_act && run;
      set2[6]                 = chain_act && run;
      set2[hmi_pkg::ST2_OVF]  = selftest_code_wr && (wr_ptr == hmi_pkg::SELFTEST_CODE_FULL);
   end

   // Read-to-clear status. A new event in the clearing cycle survives; the
   // line-clear bit does not touch these flags.
   always_ff @(posedge SYS_CLK) begin
      if (SRST || soft_init) begin
         stat1 <= 8'h00;
         stat2 <= 8'h00;
      end else begin
         stat1 <= (clear1 ? 8'h00 : stat1) | set1;
         stat2 <= (clear2 ? 8'h00 : stat2) | set2;
      end
   end

   // Self-test code store; the host write pointer stops once full.
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         wr_ptr <= 6'h00;
      end else if (selftest_code_wr && wr_ptr != hmi_pkg::SELFTEST_CODE_FULL) begin
         wr_ptr <= wr_ptr + 6'h01;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (selftest_code_wr && wr_ptr != hmi_pkg::SELFTEST_CODE_FULL) begin
         selftest_code_mem[wr_ptr[4:0]] <= WDATA;
      end else if (wr_data && in_selftest_code) begin
         selftest_code_mem[index[4:0]] <= WDATA;
      end
   end

   // Read data.
   always_comb begin
      rd_value = 8'h00;
      if (ADDR == hmi_pkg::PORT_INDEX) begin
         rd_value = {1'b0, index};
      end else if (ADDR == hmi_pkg::PORT_DATA) begin
         if (in_selftest_code) begin
            rd_value = selftest_code_mem[index[4:0]];
         end else begin
            unique case (index)
               hmi_pkg::IDX_CFG:        rd_value = cfg;
               hmi_pkg::IDX_STAT1:      rd_value = stat1;
               hmi_pkg::IDX_STAT2:      rd_value = stat2;
               hmi_pkg::IDX_MGMT_MASK1: rd_value = mgmt_mask1;
               hmi_pkg::IDX_MGMT_MASK2: rd_value = mgmt_mask2;
               hmi_pkg::IDX_HOST_MASK1: rd_value = host_mask1;
               hmi_pkg::IDX_HOST_MASK2: rd_value = host_mask2;
               hmi_pkg::IDX_OVER_TEMP:  rd_value = over_temp_limit;
               hmi_pkg::IDX_HYST:       rd_value = temp_hysteresis_limit;
               default:                 rd_value = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         RDATA <= 8'h00;
      end else begin
         RDATA <= RD ? rd_value : 8'h00;
      end
   end

   // Timed pulses: channel 0 is the reset output, channel 1 the chassis line.
   assign pulse_trig[0] = cfg[hmi_pkg::CFG_RESET] && mgmt_mask2[hmi_pkg::MASK2_PULSE];
   assign pulse_trig[1] = host_mask2[hmi_pkg::MASK2_PULSE];

   for (genvar p = 0; p < 2; p++) begin : g_pulse
      assign pulse_done[p] = pulse_busy[p] && (pulse_cnt[p] == PULSE_END);
      always_ff @(posedge SYS_CLK) begin
         if (SRST || soft_init) begin
            pulse_busy[p] <= 1'b0;
            pulse_cnt[p]  <= 19'h00000;
         end else if (pulse_busy[p]) begin
            pulse_busy[p] <= !pulse_done[p];
            pulse_cnt[p]  <= pulse_cnt[p] + 19'h00001;
         end else if (pulse_trig[p]) begin
            pulse_busy[p] <= 1'b1;
            pulse_cnt[p]  <= 19'h00000;
         end
      end
   end

   // Board test mode: entered only from the reset configuration before any
   // configuration write, and left only by reset.
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         tree_mode <= 1'b0;
      end else if (!cfg_written && cfg == hmi_pkg::CFG_RST && !mgmt_pin) begin
         tree_mode <= 1'b1;
      end
   end

   // With every pin high each stage passes its upstream value on, so any single
   // pin that toggles also toggles the output, wherever it sits in the chain.
   assign chain[0] = sync_b[0];
   for (genvar i = 1; i < 12; i++) begin : g_tree
      assign chain[i] = chain[i-1] & sync_b[i];
   end

   // Interrupt lines follow the flags, so a clearing read drops them.
   assign pend_mgmt = |(stat1 & ~mgmt_mask1) || |(stat2[6:0] & ~mgmt_mask2[6:0]);
   assign pend_host = |(stat1 & ~host_mask1) || |(stat2[6:0] & ~host_mask2[6:0]);

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         MGMT_IRQ_OE   <= 1'b0;
         HOST_IRQ_N    <= 1'b1;
         HOST_IRQ_OE   <= 1'b1;
         HOST_IRQ_NMI  <= 1'b0;
         MON_RUN       <= 1'b0;
         HOLD_OE       <= 1'b0;
         RESET_OE      <= 1'b0;
         CHASSIS_OE    <= 1'b0;
         TREE_TEST_OUT <= 1'b0;
      end else begin
         MGMT_IRQ_OE   <= cfg[hmi_pkg::CFG_MGMT_EN] && !cfg[hmi_pkg::CFG_LINE_CLEAR]
                          && pend_mgmt && !tree_mode;
         HOST_IRQ_N    <= !(cfg[hmi_pkg::CFG_HOST_EN] && !cfg[hmi_pkg::CFG_LINE_CLEAR]
                          && pend_host);
         HOST_IRQ_OE   <= !tree_mode;
         HOST_IRQ_NMI  <= cfg[hmi_pkg::CFG_HOST_SEL];
         MON_RUN       <= run;
         HOLD_OE       <= cfg[hmi_pkg::CFG_HOLD];
         RESET_OE      <= pulse_busy[0];
         CHASSIS_OE    <= pulse_busy[1] && !tree_mode;
         TREE_TEST_OUT <= chain[11];
      end
   end

   // Open-drain pins only ever drive low.
   always_ff @(posedge SYS_CLK) begin
      MGMT_IRQ_O <= 1'b0;
      RESET_O    <= 1'b0;
      HOLD_O     <= 1'b0;
      CHASSIS_O  <= 1'b0;
   end

   a_temp_hold:
      assert property (@(posedge SYS_CLK) disable iff (SRST)
         stat1[hmi_pkg::ST1_TEMP] && !clear1 && !soft_init |=> stat1[hmi_pkg::ST1_TEMP])
      else $error("Temperature flag dropped without a read.");

   a_thermo_set:
      assert property (@(posedge SYS_CLK) disable iff (SRST)
         MEAS_DONE && run && !soft_init && temp_hysteresis_limit == hmi_pkg::THERMOSTAT
         && $signed(TEMP_VALUE) > $signed(over_temp_limit) |=> stat1[hmi_pkg::ST1_TEMP])
      else $error("Thermostat mode did not set temperature flag.");

   a_read_clear:
      assert property (@(posedge SYS_CLK) disable iff (SRST)
         clear1 && set1 == 8'h00 && stat2 == 8'h00 && set2 == 8'h00
         |=> stat1 == 8'h00 ##1 !MGMT_IRQ_OE)
      else $error("Status read did not clear the register or the line.");

   a_line_clear:
      assert property (@(posedge SYS_CLK) disable iff (SRST)
         cfg[hmi_pkg::CFG_LINE_CLEAR] |=> !MGMT_IRQ_OE && HOST_IRQ_N && !MON_RUN)
      else $error("Line clear did not silence the outputs.");

   a_mgmt_assert:
      assert property (@(posedge SYS_CLK) disable iff (SRST)
         cfg[hmi_pkg::CFG_MGMT_EN] && !cfg[hmi_pkg::CFG_LINE_CLEAR] && pend_mgmt && !tree_mode
         |=> MGMT_IRQ_OE && !MGMT_IRQ_O)
      else $error("Management line failed to assert.");

   a_mask_block:
      assert property (@(posedge SYS_CLK) disable iff (SRST)
         !pend_mgmt |=> !MGMT_IRQ_OE)
      else $error("Masked flag drove the management line.");

   a_selftest_code_stop:
      assert property (@(posedge SYS_CLK) disable iff (SRST)
         selftest_code_wr && wr_ptr == hmi_pkg::SELFTEST_CODE_FULL && !soft_init
         |=> wr_ptr == hmi_pkg::SELFTEST_CODE_FULL && stat2[hmi_pkg::ST2_OVF])
      else $error("Store overflow not flagged or pointer moved.");

   a_selftest_code_advance:
      assert property (@(posedge SYS_CLK) disable iff (SRST)
         selftest_code_wr && wr_ptr != hmi_pkg::SELFTEST_CODE_FULL |=> wr_ptr == $past(wr_ptr) + 6'h01)
      else $error("Store write pointer did not advance.");

   a_hold_drive:
      assert property (@(posedge SYS_CLK) disable iff (SRST)
         cfg[hmi_pkg::CFG_HOLD] |=> HOLD_OE && !HOLD_O)
      else $error("Supply-hold output not driven low.");

   a_reset_gate:
      assert property (@(posedge SYS_CLK) disable iff (SRST)
         !mgmt_mask2[hmi_pkg::MASK2_PULSE] && !pulse_busy[0] |-> ##2 !RESET_OE)
      else $error("Reset output ran without its enable.");

   a_reset_width:
      assert property (@(posedge SYS_CLK) disable iff (SRST || soft_init)
         $rose(RESET_OE) |-> RESET_OE[*8])
      else $error("Reset pulse too short.");

   a_chassis_width:
      assert property (@(posedge SYS_CLK) disable iff (SRST || soft_init)
         $rose(CHASSIS_OE) |-> CHASSIS_OE[*8])
      else $error("Chassis pulse too short.");

endmodule

`default_nettype wire

// >>> verif/hmi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Board side of the open-drain lines: pull-ups, the tester's clip and an
// intrusion latch that the device's own pull clears, as a real one would.
module hmi_host_model (
   // Clock
   input  wire logic clk,
   // Device drivers
   input  wire logic mgmt_o,
   input  wire logic mgmt_oe,
   input  wire logic chassis_oe,
   input  wire logic reset_oe,
   input  wire logic hold_oe,
   // Board stimulus
   input  wire logic tst_pull,
   input  wire logic intr_set,
   // Resolved lines
   output logic      mgmt_line,
   output logic      chassis_line,
   output logic      reset_line,
   output logic      hold_line
);
   logic intr = 1'b0;
   always @(posedge clk) begin
      if (chassis_oe) begin
         intr <= 1'b0;
      end else if (intr_set) begin
         intr <= 1'b1;
      end
   end
   assign mgmt_line    = (mgmt_oe ? mgmt_o : 1'b1) & ~tst_pull;
   assign chassis_line = ~chassis_oe & intr;
   assign reset_line   = ~reset_oe;
   assign hold_line    = ~hold_oe;
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       clk = 1'b0;
   logic       srst = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] temp = 8'h00;
   logic [7:0] tree = 8'hff;
   logic [6:0] volt = 7'h00;
   logic [2:0] fan = 3'h0;
   logic       wr = 1'b0, rd = 1'b0, meas = 1'b0, bti_n = 1'b1, chained_n = 1'b1;
   logic       tst_pull = 1'b0, intr_set = 1'b0;
   logic [7:0] rdata;
   logic       mon_run, chassis_o, chassis_oe, mgmt_o, mgmt_oe, host_n, host_oe, nmi;
   logic       reset_o, reset_oe, hold_o, hold_oe, tree_out;
   logic       mgmt_line, chassis_line, reset_line, hold_line;
   logic [1:0] pl;
   int         miscompares = 0;
   int         num_checks = 0;
   localparam logic [7:0] HOT = hmi_pkg::OVER_TEMP_RST + 8'h01;
   localparam logic [7:0] COOL = hmi_pkg::HYST_RST - 8'h01;
   assign pl = {reset_line, ~chassis_oe};
   always #20 clk = ~clk;
   hmi_top #(.PULSE_CYCLES(20)) u_hmi_top (
      .SYS_CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .MEAS_DONE(meas), .TEMP_VALUE(temp), .VOLT_FAULT(volt),
      .FAN_FAULT(fan), .MON_RUN(mon_run), .BTI_N(bti_n), .CHAINED_N(chained_n),
      .CHASSIS_I(chassis_line), .CHASSIS_O(chassis_o), .CHASSIS_OE(chassis_oe),
      .MGMT_IRQ_I(mgmt_line), .MGMT_IRQ_O(mgmt_o), .MGMT_IRQ_OE(mgmt_oe),
      .HOST_IRQ_N(host_n), .HOST_IRQ_OE(host_oe), .HOST_IRQ_NMI(nmi),
      .RESET_O(reset_o), .RESET_OE(reset_oe), .HOLD_O(hold_o), .HOLD_OE(hold_oe),
      .TREE_IN(tree), .TREE_TEST_OUT(tree_out));
   hmi_host_model u_hmi_host_model (
      .clk(clk), .mgmt_o(mgmt_o), .mgmt_oe(mgmt_oe), .chassis_oe(chassis_oe),
      .reset_oe(reset_oe), .hold_oe(hold_oe), .tst_pull(tst_pull), .intr_set(intr_set),
      .mgmt_line(mgmt_line), .chassis_line(chassis_line), .reset_line(reset_line),
      .hold_line(hold_line));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic put(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic get(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rput(input logic [6:0] i, input logic [7:0] d);
      put(hmi_pkg::PORT_INDEX, {1'b0, i});
      put(hmi_pkg::PORT_DATA, d);
   endtask
   task automatic rchk(input logic [6:0] i, input logic [7:0] e);
      logic [7:0] d;
      put(hmi_pkg::PORT_INDEX, {1'b0, i});
      get(hmi_pkg::PORT_DATA, d);
      chk(d, e);
   endtask
   // One measurement cycle; returns once the interrupt lines have settled, so
   // status reads always follow a finished loop and see fresh flags.
   task automatic run(input logic [7:0] t, input logic [6:0] v, input logic [2:0] f);
      @(posedge clk);
      meas <= 1'b1;
      temp <= t;
      volt <= v;
      fan <= f;
      @(posedge clk);
      meas <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // Counts low cycles of a line over a window longer than any pulse.
   task automatic plen(input int s, output int n);
      n = 0;
      repeat (40) begin
         @(posedge clk);
         #1 if (pl[s] === 1'b0) n++;
      end
   endtask
   task automatic t_temp;
      rput(hmi_pkg::IDX_CFG, 8'h03);
      run(HOT, 7'h00, 3'h0);
      chk(mgmt_line, 1'b0);
      rchk(hmi_pkg::IDX_STAT1, 8'h10);
      repeat (2) @(posedge clk);
      #1 chk(mgmt_line, 1'b1);
      run(HOT, 7'h00, 3'h0);
      rchk(hmi_pkg::IDX_STAT1, 8'h00);
      run(COOL, 7'h00, 3'h0);
      rchk(hmi_pkg::IDX_STAT1, 8'h10);
      rput(hmi_pkg::IDX_HYST, hmi_pkg::THERMOSTAT);
      run(HOT, 7'h00, 3'h0);
      rchk(hmi_pkg::IDX_STAT1, 8'h10);
      run(HOT, 7'h00, 3'h0);
      run(COOL, 7'h00, 3'h0);
      run(COOL, 7'h00, 3'h0);
      rchk(hmi_pkg::IDX_STAT1, 8'h10);
      run(COOL, 7'h00, 3'h0);
      rchk(hmi_pkg::IDX_STAT1, 8'h00);
      $display("t_temp done");
   endtask
   task automatic t_mask;
      rput(hmi_pkg::IDX_MGMT_MASK1, 8'h01);
      rput(hmi_pkg::IDX_CFG, 8'h07);
      run(COOL, 7'h01, 3'h0);
      chk(mgmt_line, 1'b1);
      chk(host_n, 1'b0);
      chk(nmi, 1'b0);
      rput(hmi_pkg::IDX_CFG, 8'h2f);
      repeat (3) @(posedge clk);
      #1 chk(host_n, 1'b1);
      chk(mon_run, 1'b0);
      chk(nmi, 1'b1);
      rchk(hmi_pkg::IDX_STAT1, 8'h01);
      rput(hmi_pkg::IDX_MGMT_MASK1, 8'h00);
      rput(hmi_pkg::IDX_CFG, 8'h03);
      run(COOL, 7'h01, 3'h0);
      chk(host_n, 1'b1);
      chk(mgmt_line, 1'b0);
      rchk(hmi_pkg::IDX_STAT1, 8'h01);
      $display("t_mask done");
   endtask
   task automatic t_src;
      @(posedge clk);
      bti_n <= 1'b0;
      chained_n <= 1'b0;
      intr_set <= 1'b1;
      run(COOL, 7'h7f, 3'h7);
      repeat (4) @(posedge clk);
      intr_set <= 1'b0;
      bti_n <= 1'b1;
      chained_n <= 1'b1;
      rchk(hmi_pkg::IDX_STAT1, 8'hef);
      rchk(hmi_pkg::IDX_STAT2, 8'h5f);
      $display("t_src done");
   endtask
   task automatic t_pulse;
      int n;
      rput(hmi_pkg::IDX_HOST_MASK2, 8'hc0);
      plen(0, n);
      chk(8'(n), 8'h14);
      rchk(hmi_pkg::IDX_HOST_MASK2, 8'h40);
      rput(hmi_pkg::IDX_CFG, 8'h13);
      plen(1, n);
      chk(8'(n), 8'h00);
      rput(hmi_pkg::IDX_CFG, 8'h03);
      rput(hmi_pkg::IDX_MGMT_MASK2, 8'h80);
      rput(hmi_pkg::IDX_CFG, 8'h13);
      plen(1, n);
      chk(8'(n), 8'h14);
      rchk(hmi_pkg::IDX_CFG, 8'h03);
      rput(hmi_pkg::IDX_CFG, 8'h43);
      repeat (2) @(posedge clk);
      #1 chk(hold_line, 1'b0);
      rput(hmi_pkg::IDX_CFG, 8'h03);
      repeat (2) @(posedge clk);
      #1 chk(hold_line, 1'b1);
      chk({5'h00, chassis_o, reset_o, hold_o}, 8'h00);
      $display("t_pulse done");
   endtask
   task automatic t_selftest_code;
      logic [7:0] d;
      rchk(hmi_pkg::IDX_STAT2, 8'h10);
      for (int i = 0; i < 33; i++) begin
         put(i[0] ? hmi_pkg::PORT_SELFTEST_CODE_B : hmi_pkg::PORT_SELFTEST_CODE_A, 8'(i));
      end
      rchk(hmi_pkg::IDX_STAT2, 8'h20);
      put(hmi_pkg::PORT_INDEX, 8'h00);
      for (int i = 0; i < 32; i++) begin
         get(hmi_pkg::PORT_DATA, d);
         chk(d, 8'(i));
      end
      rput(hmi_pkg::IDX_CFG, 8'h80);
      rchk(hmi_pkg::IDX_CFG, hmi_pkg::CFG_RST);
      rchk(hmi_pkg::IDX_MGMT_MASK2, hmi_pkg::MASK_RST);
      $display("t_selftest_code done");
   endtask
   task automatic t_tree;
      @(posedge clk);
      srst <= 1'b1;
      tst_pull <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      repeat (6) @(posedge clk);
      tst_pull <= 1'b0;
      intr_set <= 1'b1;
      @(posedge clk);
      intr_set <= 1'b0;
      repeat (6) @(posedge clk);
      #1 chk(host_oe, 1'b0);
      chk(tree_out, 1'b1);
      @(posedge clk);
      tree[2] <= 1'b0;
      repeat (6) @(posedge clk);
      #1 chk(tree_out, 1'b0);
      $display("t_tree done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      t_temp;
      t_mask;
      t_src;
      t_pulse;
      t_selftest_code;
      t_tree;
      finish_test;
   end
   initial begin
      repeat (6000) @(posedge clk);
      miscompares++;
      finish_test;
   end
endmodule
`default_nettype wire
